/* rtl/aiip_consts.svh */
// register indices, field positions, reset values of the analog input image packer
`ifndef AIIP_CONSTS_SVH
`define AIIP_CONSTS_SVH

`define AIIP_ADDR_W 8
`define AIIP_DATA_W 32
`define AIIP_CHAN_N 4
`define AIIP_RES_W 12
`define AIIP_WORD_W 16

// word indices; byte address is four times the index
`define AIIP_IDX_CH0 6'h00
`define AIIP_IDX_CH1 6'h01
`define AIIP_IDX_CH2 6'h02
`define AIIP_IDX_CH3 6'h03
`define AIIP_IDX_FLAGS 6'h04
`define AIIP_IDX_EXP 6'h05
`define AIIP_IDX_CTRL 6'h08
`define AIIP_IDX_REFRESH 6'h09

// control word fields
`define AIIP_CTRL_RANGE_LSB 0
`define AIIP_CTRL_RANGE_MSB 3
`define AIIP_CTRL_EXP_LSB 4
`define AIIP_CTRL_EXP_MSB 5
`define AIIP_CTRL_W 6
`define AIIP_CTRL_RST 6'h00

`define AIIP_IMAGE_RST 16'h0000
`define AIIP_RESP_OKAY 2'b00
`define AIIP_RESP_SLVERR 2'b10

`endif

/* rtl/aiip_pkg.sv */
// types and helpers of the analog input image packer
package aiip_pkg;

  typedef enum logic [1:0] {
    AIIP_EXP_NONE = 2'b00,
    AIIP_EXP_EIGHT = 2'b01,
    AIIP_EXP_SIXTEEN = 2'b10,
    AIIP_EXP_RSVD = 2'b11
  } aiip_exp_mode_t;

  // byte address to word index; the low two bits are ignored
  function automatic logic [5:0] aiip_word_index(input logic [7:0] byte_addr);
    return byte_addr[7:2];
  endfunction : aiip_word_index

endpackage : aiip_pkg

/* rtl/aiip_flag_if.sv */
// fault causes in, per-channel status flags out, between top and flag generator
interface aiip_flag_if;
  logic field_power_ok_pin;
  logic [3:0] open_wire;
  logic [3:0] under_range;
  logic [3:0] range_4to20;
  logic fault_recoverable;
  logic fault_unrecoverable;
  logic [3:0] chan_fault_flags;

  modport gen (
    input field_power_ok_pin,
    input open_wire,
    input under_range,
    input range_4to20,
    input fault_recoverable,
    input fault_unrecoverable,
    output chan_fault_flags
  );

  modport top (
    output field_power_ok_pin,
    output open_wire,
    output under_range,
    output range_4to20,
    output fault_recoverable,
    output fault_unrecoverable,
    input chan_fault_flags
  );
endinterface : aiip_flag_if

/* rtl/aiip_flag_gen.sv */
// per-channel status flag generation
`include "aiip_consts.svh"

module aiip_flag_gen (
  input wire logic aclk,
  input wire logic aresetn,
  aiip_flag_if.gen flg
);

  logic pwr_meta_reg;
  logic pwr_ok_reg;

  // field power arrives from a pin
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pwr_meta_reg <= 1'b0;
      pwr_ok_reg <= 1'b0;
    end else begin
      pwr_meta_reg <= flg.field_power_ok_pin;
      pwr_ok_reg <= pwr_meta_reg;
    end
  end

  // one field supply feeds all channels, so its loss flags each of them
  wire [3:0] power_missing = {4{~pwr_ok_reg}};
  wire [3:0] loop_fault = flg.range_4to20 & (flg.open_wire | flg.under_range);
  wire [3:0] module_fault = {4{flg.fault_recoverable | flg.fault_unrecoverable}};

  assign flg.chan_fault_flags = power_missing | loop_fault | module_fault;

endmodule : aiip_flag_gen

/* rtl/aiip_exp_pack.sv */
// discrete expansion input synchroniser and word packing
`include "aiip_consts.svh"

module aiip_exp_pack (
  input wire logic aclk,
  input wire logic aresetn,
  input wire aiip_pkg::aiip_exp_mode_t exp_mode,
  input wire logic [15:0] exp_pins,
  output logic [15:0] exp_word
);

  logic [15:0] meta_reg;
  logic [15:0] sync_reg;
  logic [15:0] exp_word_reg;
  logic [15:0] exp_word_next;

  wire expansion_input_eighth = sync_reg[7];
  wire expansion_input_highest = sync_reg[15];

  always_comb begin
    unique case (exp_mode)
      aiip_pkg::AIIP_EXP_NONE: exp_word_next = `AIIP_IMAGE_RST;
      aiip_pkg::AIIP_EXP_EIGHT: exp_word_next = {8'h00, expansion_input_eighth, sync_reg[6:0]};
      aiip_pkg::AIIP_EXP_SIXTEEN: exp_word_next = {expansion_input_highest, sync_reg[14:0]};
      default: exp_word_next = `AIIP_IMAGE_RST;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      meta_reg <= 16'h0000;
      sync_reg <= 16'h0000;
      exp_word_reg <= `AIIP_IMAGE_RST;
    end else begin
      meta_reg <= exp_pins;
      sync_reg <= meta_reg;
      exp_word_reg <= exp_word_next;
    end
  end

  assign exp_word = exp_word_reg;

endmodule : aiip_exp_pack

/* rtl/aiip_top.sv */
// analog input image packer: snapshot of channel data, status flags and expansion inputs over axi4-lite
//
// Functional notes
// - channel results sit in bits 0..11 of words 0..3, upper four bits zero
// - channel status flags sit in bits 0..3 of word 4, rest zero
// - flag set on missing field power; open wire or under range only in 4-20 mA
// - any recoverable or unrecoverable module fault sets all four channel flags
// - one 8-input expansion: states in bits 0..7 of word 5, upper bits unused
// - 16 expansion inputs fill all bits of word 5, one state per bit
`include "aiip_consts.svh"

module aiip_top (
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite slave
  input wire logic [7:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // conversion side, same clock
  input wire logic [47:0] conv_results,
  input wire logic conv_done,
  input wire logic [3:0] open_wire_det,
  input wire logic [3:0] under_range_det,
  input wire logic fault_recoverable,
  input wire logic fault_unrecoverable,
  // pins
  input wire logic field_power_ok,
  input wire logic [15:0] exp_inputs
);

  // ---------------------------------------------------------------
  // control and image state
  // ---------------------------------------------------------------
  logic [`AIIP_CTRL_W-1:0] ctrl_reg;
  logic [`AIIP_RES_W-1:0] chan_result_reg [0:`AIIP_CHAN_N-1];
  logic [3:0] chan_fault_flags_reg;
  logic [15:0] exp_image_reg;
  logic [15:0] refresh_count_reg;

  wire [3:0] range_4to20 = ctrl_reg[`AIIP_CTRL_RANGE_MSB:`AIIP_CTRL_RANGE_LSB];
  wire aiip_pkg::aiip_exp_mode_t exp_mode =
    aiip_pkg::aiip_exp_mode_t'(ctrl_reg[`AIIP_CTRL_EXP_MSB:`AIIP_CTRL_EXP_LSB]);

  // ---------------------------------------------------------------
  // flag generator and expansion packer
  // ---------------------------------------------------------------
  aiip_flag_if flg ();

  assign flg.field_power_ok_pin = field_power_ok;
  assign flg.open_wire = open_wire_det;
  assign flg.under_range = under_range_det;
  assign flg.range_4to20 = range_4to20;
  assign flg.fault_recoverable = fault_recoverable;
  assign flg.fault_unrecoverable = fault_unrecoverable;

  aiip_flag_gen u_flag_gen (
    .aclk(aclk),
    .aresetn(aresetn),
    .flg(flg.gen)
  );

  wire [15:0] exp_word;

  aiip_exp_pack u_exp_pack (
    .aclk(aclk),
    .aresetn(aresetn),
    .exp_mode(exp_mode),
    .exp_pins(exp_inputs),
    .exp_word(exp_word)
  );

  // ---------------------------------------------------------------
  // image snapshot
  // ---------------------------------------------------------------
  // the count wraps; software compares two reads to see that a refresh happened
  wire [15:0] refresh_count_next = refresh_count_reg + 16'h0001;

  // every word loads on the same edge so no read mixes two conversions
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      for (int i = 0; i < `AIIP_CHAN_N; i++) begin
        chan_result_reg[i] <= 12'h000;
      end
      chan_fault_flags_reg <= 4'h0;
      exp_image_reg <= `AIIP_IMAGE_RST;
      refresh_count_reg <= 16'h0000;
    end else if (conv_done) begin
      for (int i = 0; i < `AIIP_CHAN_N; i++) begin
        chan_result_reg[i] <= conv_results[i*`AIIP_RES_W +: `AIIP_RES_W];
      end
      chan_fault_flags_reg <= flg.chan_fault_flags;
      exp_image_reg <= exp_word;
      refresh_count_reg <= refresh_count_next;
    end
  end

  // ---------------------------------------------------------------
  // read decode
  // ---------------------------------------------------------------
  // one compare per word, so a later index can never alias a channel
  wire [5:0] rd_idx = aiip_pkg::aiip_word_index(s_axi_araddr);
  wire rd_is_ch0 = (rd_idx == `AIIP_IDX_CH0);
  wire rd_is_ch1 = (rd_idx == `AIIP_IDX_CH1);
  wire rd_is_ch2 = (rd_idx == `AIIP_IDX_CH2);
  wire rd_is_ch3 = (rd_idx == `AIIP_IDX_CH3);
  wire rd_is_chan = rd_is_ch0 | rd_is_ch1 | rd_is_ch2 | rd_is_ch3;
  wire rd_is_flags = (rd_idx == `AIIP_IDX_FLAGS);
  wire rd_is_exp = (rd_idx == `AIIP_IDX_EXP);
  wire rd_is_ctrl = (rd_idx == `AIIP_IDX_CTRL);
  wire rd_is_refresh = (rd_idx == `AIIP_IDX_REFRESH);
  wire rd_hit = rd_is_chan | rd_is_flags | rd_is_exp | rd_is_ctrl | rd_is_refresh;

  // ---------------------------------------------------------------
  // image words as the controller sees them
  // ---------------------------------------------------------------
  // unused upper bits of the channel, flag and control words are wired to zero rather than stored
  wire [15:0] channel0_result = {4'h0, chan_result_reg[0]};
  wire [15:0] channel1_result = {4'h0, chan_result_reg[1]};
  wire [15:0] channel2_result = {4'h0, chan_result_reg[2]};
  wire [15:0] channel3_result = {4'h0, chan_result_reg[3]};
  wire [15:0] channel_fault_flags = {12'h000, chan_fault_flags_reg};
  wire [15:0] expansion_discrete_inputs = exp_image_reg;
  wire [15:0] ctrl_word = {10'h000, ctrl_reg};

  // every register sits in the low half of the 32-bit bus word
  wire [15:0] rd_word =
    rd_is_ch0 ? channel0_result :
    rd_is_ch1 ? channel1_result :
    rd_is_ch2 ? channel2_result :
    rd_is_ch3 ? channel3_result :
    rd_is_flags ? channel_fault_flags :
    rd_is_exp ? expansion_discrete_inputs :
    rd_is_ctrl ? ctrl_word :
    rd_is_refresh ? refresh_count_reg : 16'h0000;
  wire [31:0] rd_mux = {16'h0000, rd_word};

  // ---------------------------------------------------------------
  // read channel
  // ---------------------------------------------------------------
  logic rvalid_reg;
  logic [31:0] rdata_reg;
  logic [1:0] rresp_reg;

  assign s_axi_arready = !rvalid_reg;
  wire ar_take = s_axi_arvalid && s_axi_arready;
  wire r_done = rvalid_reg && s_axi_rready;

  // data and response load only on a take, so they stand until rready
  wire rvalid_next = ar_take ? 1'b1 : (r_done ? 1'b0 : rvalid_reg);
  wire [31:0] rdata_next = ar_take ? rd_mux : rdata_reg;
  wire [1:0] rresp_next = ar_take ? (rd_hit ? `AIIP_RESP_OKAY : `AIIP_RESP_SLVERR) : rresp_reg;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_reg <= 1'b0;
      rdata_reg <= 32'h00000000;
      rresp_reg <= `AIIP_RESP_OKAY;
    end else begin
      rvalid_reg <= rvalid_next;
      rdata_reg <= rdata_next;
      rresp_reg <= rresp_next;
    end
  end

  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rdata = rdata_reg;
  assign s_axi_rresp = rresp_reg;

  // ---------------------------------------------------------------
  // write channel
  // ---------------------------------------------------------------
  logic aw_held_reg;
  logic [7:0] aw_addr_reg;
  logic w_held_reg;
  logic [31:0] w_data_reg;
  logic [3:0] w_strb_reg;
  logic bvalid_reg;
  logic [1:0] bresp_reg;

  // one write in flight; address and data may come in either order
  assign s_axi_awready = !aw_held_reg && !bvalid_reg;
  assign s_axi_wready = !w_held_reg && !bvalid_reg;
  wire aw_take = s_axi_awvalid && s_axi_awready;
  wire w_take = s_axi_wvalid && s_axi_wready;
  wire do_write = aw_held_reg && w_held_reg && !bvalid_reg;
  wire b_done = bvalid_reg && s_axi_bready;

  // image words are read-only; writing them is answered with an error
  wire [5:0] wr_idx = aiip_pkg::aiip_word_index(aw_addr_reg);
  wire wr_is_ctrl = (wr_idx == `AIIP_IDX_CTRL);
  // control bits all live in the low byte, so only its strobe counts
  wire ctrl_load = do_write && wr_is_ctrl && w_strb_reg[0];

  wire aw_held_next = aw_take ? 1'b1 : (do_write ? 1'b0 : aw_held_reg);
  wire [7:0] aw_addr_next = aw_take ? s_axi_awaddr : aw_addr_reg;
  wire w_held_next = w_take ? 1'b1 : (do_write ? 1'b0 : w_held_reg);
  wire [31:0] w_data_next = w_take ? s_axi_wdata : w_data_reg;
  wire [3:0] w_strb_next = w_take ? s_axi_wstrb : w_strb_reg;
  wire bvalid_next = do_write ? 1'b1 : (b_done ? 1'b0 : bvalid_reg);
  wire [1:0] bresp_next = do_write ? (wr_is_ctrl ? `AIIP_RESP_OKAY : `AIIP_RESP_SLVERR) : bresp_reg;
  wire [`AIIP_CTRL_W-1:0] ctrl_next = ctrl_load ? w_data_reg[`AIIP_CTRL_W-1:0] : ctrl_reg;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_reg <= 1'b0;
      aw_addr_reg <= 8'h00;
    end else begin
      aw_held_reg <= aw_held_next;
      aw_addr_reg <= aw_addr_next;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_held_reg <= 1'b0;
      w_data_reg <= 32'h00000000;
      w_strb_reg <= 4'h0;
    end else begin
      w_held_reg <= w_held_next;
      w_data_reg <= w_data_next;
      w_strb_reg <= w_strb_next;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_reg <= 1'b0;
      bresp_reg <= `AIIP_RESP_OKAY;
    end else begin
      bvalid_reg <= bvalid_next;
      bresp_reg <= bresp_next;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_reg <= `AIIP_CTRL_RST;
    end else begin
      ctrl_reg <= ctrl_next;
    end
  end

  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp = bresp_reg;

endmodule : aiip_top

/* tb/aiip_ctrl_model.sv */
// axi4-lite master model of the controller scanning the input image
module aiip_ctrl_model (
  input wire logic aclk,
  output logic [7:0] s_axi_awaddr,
  output logic s_axi_awvalid,
  input wire logic s_axi_awready,
  output logic [31:0] s_axi_wdata,
  output logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  output logic s_axi_bready,
  output logic [7:0] s_axi_araddr,
  output logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  output logic s_axi_rready
);
  timeunit 1ns;
  timeprecision 1ps;
  // cycles of stall before taking an answer, set by the bench
  int lag = 0;
  initial begin
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
    {s_axi_awaddr, s_axi_wdata, s_axi_araddr} = 48'h0;
  end
  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] resp);
    logic aw_ok;
    logic w_ok;
    aw_ok = 1'h0;
    w_ok = 1'h0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    while (!(aw_ok && w_ok)) begin
      @(posedge aclk);
      aw_ok = aw_ok || s_axi_awready;
      w_ok = w_ok || s_axi_wready;
      s_axi_awvalid <= !aw_ok;
      s_axi_wvalid <= !w_ok;
    end
    // released payload must not look valid
    s_axi_awaddr <= ~a;
    s_axi_wdata <= ~d;
    repeat (lag) @(posedge aclk);
    s_axi_bready <= 1'h1;
    do @(posedge aclk); while (s_axi_bvalid !== 1'h1);
    resp = s_axi_bresp;
    s_axi_bready <= 1'h0;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] resp);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    do @(posedge aclk); while (s_axi_arready !== 1'h1);
    s_axi_arvalid <= 1'h0;
    s_axi_araddr <= ~a;
    repeat (lag) @(posedge aclk);
    s_axi_rready <= 1'h1;
    do @(posedge aclk); while (s_axi_rvalid !== 1'h1);
    d = s_axi_rdata;
    resp = s_axi_rresp;
    s_axi_rready <= 1'h0;
  endtask : rd
  // a channel word is only worth using while its status flag is clear
  function automatic logic usable(input logic [31:0] flags_word, input int chan);
    return !flags_word[chan];
  endfunction : usable
endmodule : aiip_ctrl_model

/* tb/aiip_top_sva.sv */
// handshake and image layout assertions of the packer
module aiip_top_sva (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read not answered");
  a_read_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data not held");
  a_read_one: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("second read accepted");
  a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |=> ##1 s_axi_bvalid)
    else $error("write not answered");
  a_resp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write response dropped");
  a_write_one: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("second write accepted");
  a_chan_layout: assert property (
    s_axi_arvalid && s_axi_arready && s_axi_araddr[7:4] == 4'h0 |=> s_axi_rdata[31:12] == 20'h0)
    else $error("channel word upper bits set");
  a_flag_layout: assert property (
    s_axi_arvalid && s_axi_arready && s_axi_araddr[7:2] == 6'h04 |=> s_axi_rdata[31:4] == 28'h0)
    else $error("flag word upper bits set");
endmodule : aiip_top_sva
bind aiip_top aiip_top_sva i_sva (.*);

/* tb/aiip_top_tb.sv */
// self-checking bench of the analog input image packer
module aiip_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {
    logic [5:0] ctrl;
    logic pwr;
    logic [3:0] ow;
    logic [3:0] ur;
    logic [1:0] flt;
    logic [3:0] flags;
    logic [15:0] word5;
  } aiip_row_t;
  // ctrl: range enables [3:0], expansion mode [5:4]; pins carry 16'ha5c3
  localparam aiip_row_t rows [6] = '{
    '{6'h00, 1'h1, 4'hf, 4'h0, 2'h0, 4'h0, 16'h0000},
    '{6'h15, 1'h1, 4'h3, 4'h8, 2'h0, 4'h1, 16'h00c3},
    '{6'h2a, 1'h1, 4'h0, 4'hf, 2'h0, 4'ha, 16'ha5c3},
    '{6'h3f, 1'h1, 4'h0, 4'h0, 2'h2, 4'hf, 16'h0000},
    '{6'h20, 1'h1, 4'h0, 4'h0, 2'h1, 4'hf, 16'ha5c3},
    '{6'h10, 1'h0, 4'h0, 4'h0, 2'h0, 4'hf, 16'h00c3}};
  logic aclk = 1'h0;
  logic aresetn = 1'h0;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [2:0] s_axi_awprot = 3'h0, s_axi_arprot = 3'h0;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic [47:0] conv_results = 48'h0;
  logic conv_done = 1'h0, fault_recoverable = 1'h0, fault_unrecoverable = 1'h0, field_power_ok = 1'h1;
  logic [3:0] open_wire_det = 4'h0, under_range_det = 4'h0;
  logic [15:0] exp_inputs = 16'ha5c3;
  int fails = 0;
  int cmp_count = 0;
  logic [31:0] d;
  logic [1:0] r;
  always #12.5 aclk = ~aclk;
  aiip_top i_dut (.*);
  aiip_ctrl_model i_ctrl (.*);
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      fails++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic rdchk(input logic [5:0] idx, input logic [31:0] exp, input logic [1:0] er);
    i_ctrl.rd({idx, 2'h0}, d, r);
    check(d, exp);
    check({30'h0, r}, {30'h0, er});
  endtask : rdchk
  task automatic snap;
    conv_done <= 1'h1;
    @(posedge aclk);
    conv_done <= 1'h0;
    @(posedge aclk);
  endtask : snap
  task automatic finish_test;
    $display("compares %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : finish_test
  initial begin
    #50us;
    fails++;
    finish_test();
  end
  initial begin
    repeat (3) @(posedge aclk);
    aresetn <= 1'h1;
    @(posedge aclk);
    // indices 6 and 7 are unmapped
    for (int i = 0; i < 10; i++) rdchk(i[5:0], 32'h0, (i inside {6, 7}) ? 2'h2 : 2'h0);
    foreach (rows[k]) begin
      i_ctrl.lag = k % 3;
      i_ctrl.wr(8'h20, {26'h0, rows[k].ctrl}, r);
      check({30'h0, r}, 32'h0);
      field_power_ok <= rows[k].pwr;
      open_wire_det <= rows[k].ow;
      under_range_det <= rows[k].ur;
      {fault_recoverable, fault_unrecoverable} <= rows[k].flt;
      conv_results <= 48'h123abcfff800 ^ {12{k[3:0]}};
      // synchronisers need three cycles
      repeat (4) @(posedge aclk);
      snap();
      for (int c = 0; c < 4; c++) rdchk(c[5:0], {20'h0, conv_results[c * 12 +: 12]}, 2'h0);
      rdchk(6'h04, {28'h0, rows[k].flags}, 2'h0);
      for (int c = 0; c < 4; c++) check({31'h0, i_ctrl.usable(d, c)}, {31'h0, !rows[k].flags[c]});
      rdchk(6'h05, {16'h0, rows[k].word5}, 2'h0);
    end
    field_power_ok <= 1'h1;
    repeat (3) @(posedge aclk);
    conv_done <= 1'h1;
    @(posedge aclk);
    conv_results <= 48'hfff000aaa555;
    fault_recoverable <= 1'h1;
    @(posedge aclk);
    conv_done <= 1'h0;
    @(posedge aclk);
    rdchk(6'h00, 32'h555, 2'h0);
    rdchk(6'h03, 32'hfff, 2'h0);
    rdchk(6'h04, 32'hf, 2'h0);
    rdchk(6'h09, 32'h8, 2'h0);
    i_ctrl.wr(8'h00, 32'hffffffff, r);
    check({30'h0, r}, 32'h2);
    rdchk(6'h00, 32'h555, 2'h0);
    rdchk(6'h08, 32'h10, 2'h0);
    // low byte strobe off: control must keep its value
    s_axi_wstrb <= 4'he;
    i_ctrl.wr(8'h20, 32'h3f, r);
    check({30'h0, r}, 32'h0);
    rdchk(6'h08, 32'h10, 2'h0);
    s_axi_wstrb <= 4'hf;
    aresetn <= 1'h0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'h1;
    @(posedge aclk);
    rdchk(6'h00, 32'h0, 2'h0);
    rdchk(6'h08, 32'h0, 2'h0);
    finish_test();
  end
endmodule : aiip_top_tb
